// >>> bench/dual_pll_serial_control_latches_tb_top.sv
`timescale 1ns/1ns
module dual_pll_serial_control_latches_tb_top;
   import synth_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        hreadyout, hresp, shift_clock, serial_in, load_strobe;
   logic [13:0] if_ref_div, rf_ref_div;
   logic [5:0]  if_a_count, rf_a_count;
   logic [10:0] if_b_count, rf_b_count;
   logic        if_prescaler_sel, if_pfd_polarity, if_cp_tristate;
   logic        if_cp_current, rf_prescaler_sel, rf_pfd_polarity;
   logic        rf_cp_tristate, rf_cp_current, damping_switch_out;
   logic        synth_active;
   int          errors = 0, compares = 0;

   always #4 hclk = ~hclk;

   dual_pll_serial_control_latches dual_pll_serial_control_latches_inst (
      .hclk, .hresetn, .ce, .shift_clock, .serial_in, .load_strobe,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .if_ref_div, .if_a_count, .if_b_count, .if_prescaler_sel,
      .if_pfd_polarity, .if_cp_tristate, .if_cp_current,
      .rf_ref_div, .rf_a_count, .rf_b_count, .rf_prescaler_sel,
      .rf_pfd_polarity, .rf_cp_tristate, .rf_cp_current,
      .damping_switch_out, .synth_active);

   serial_host_model serial_host_model_inst (
      .hclk, .shift_clock, .serial_in, .load_strobe);

   task automatic print_verdict();
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         errors++;
         print_verdict();
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NSEQ;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   function automatic logic [21:0] mk_ref(logic [1:0] sel, logic [13:0] d,
                                          logic p, t, c);
      mk_ref = '0;
      mk_ref[1:0] = sel;
      mk_ref[REF_LSB +: REF_W] = d;
      mk_ref[POL_BIT] = p;
      mk_ref[TRI_BIT] = t;
      mk_ref[CUR_BIT] = c;
   endfunction

   function automatic logic [21:0] mk_ab(logic [1:0] sel, logic [5:0] a,
                                         logic [10:0] b, logic f, ps);
      mk_ab = '0;
      mk_ab[1:0] = sel;
      mk_ab[A_LSB +: A_W] = a;
      mk_ab[B_LSB +: B_W] = b;
      mk_ab[FAST_BIT] = f;
      mk_ab[PRESC_BIT] = ps;
   endfunction

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("if_cp_tristate", 32'(if_cp_tristate), 32'h1);
      ahb(1'b0, 32'(OFS_CTRL), 32'h0);
      chk("ctrl", rd, 32'h1);
      serial_host_model_inst.send(mk_ref(SEL_IF_REF, 14'h2A5C, 1, 0, 1), 1);
      chk("if_ref_div", 32'(if_ref_div), 32'h0);
      ahb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk("status", rd, 32'h1);
      serial_host_model_inst.send(mk_ab(SEL_IF_AB, 6'h2D, 11'h5B3, 0, 1), 1);
      serial_host_model_inst.send(mk_ref(SEL_RF_REF, 14'h1357, 0, 1, 0), 1);
      chk("synth_active", 32'(synth_active), 32'h0);
      serial_host_model_inst.send(mk_ab(SEL_RF_AB, 6'h11, 11'h2C4, 1, 0), 1);
      chk("synth_active", 32'(synth_active), 32'h1);
      chk("if_ref_div", 32'(if_ref_div), 32'h2A5C);
      chk("if_pfd_polarity", 32'(if_pfd_polarity), 32'h1);
      chk("if_cp_tristate", 32'(if_cp_tristate), 32'h0);
      chk("if_cp_current", 32'(if_cp_current), 32'h1);
      chk("if_a_count", 32'(if_a_count), 32'h2D);
      chk("if_b_count", 32'(if_b_count), 32'h5B3);
      chk("if_prescaler_sel", 32'(if_prescaler_sel), 32'h1);
      chk("rf_ref_div", 32'(rf_ref_div), 32'h1357);
      chk("rf_pfd_polarity", 32'(rf_pfd_polarity), 32'h0);
      chk("rf_cp_tristate", 32'(rf_cp_tristate), 32'h1);
      chk("rf_a_count", 32'(rf_a_count), 32'h11);
      chk("rf_b_count", 32'(rf_b_count), 32'h2C4);
      chk("rf_prescaler_sel", 32'(rf_prescaler_sel), 32'h0);
      chk("rf_cp_current", 32'(rf_cp_current), 32'h1);
      chk("damping", 32'(damping_switch_out), 32'h1);
      ahb(1'b0, 32'(OFS_STATUS), 32'h0);
      chk("status", rd, 32'h3F);
      // Rewrite the RF sections; the IF latches must not move.
      serial_host_model_inst.send(mk_ref(SEL_RF_REF, 14'h0AC3, 1, 0, 0), 1);
      serial_host_model_inst.send(mk_ab(SEL_RF_AB, 6'h3E, 11'h7FF, 0, 1), 1);
      chk("rf_pfd_polarity", 32'(rf_pfd_polarity), 32'h1);
      chk("rf_cp_tristate", 32'(rf_cp_tristate), 32'h0);
      chk("rf_cp_current", 32'(rf_cp_current), 32'h0);
      chk("damping", 32'(damping_switch_out), 32'h0);
      chk("rf_prescaler_sel", 32'(rf_prescaler_sel), 32'h1);
      chk("rf_b_count", 32'(rf_b_count), 32'h7FF);
      chk("if_ref_div", 32'(if_ref_div), 32'h2A5C);
      // Shifting without a load edge changes nothing.
      serial_host_model_inst.send(mk_ab(SEL_RF_AB, 6'h01, 11'h001, 1, 0), 0);
      chk("rf_a_count", 32'(rf_a_count), 32'h3E);
      ahb(1'b0, 32'(OFS_LATCH0) + 32'h14 - 32'h08, 32'h0);
      chk("rf_ab_raw", rd,
          32'(mk_ab(SEL_RF_AB, 6'h3E, 11'h7FF, 0, 1)));
      // Loads are refused while the enable bit is clear.
      ahb(1'b1, 32'(OFS_CTRL), 32'h0);
      serial_host_model_inst.send(mk_ref(SEL_IF_REF, 14'h0001, 0, 1, 0), 1);
      chk("if_ref_div", 32'(if_ref_div), 32'h2A5C);
      ahb(1'b1, 32'h100, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h100, 32'h0);
      chk("unmapped", rd, 32'h0);
      ahb(1'b0, 32'(OFS_CTRL), 32'h0);
      chk("ctrl", rd, 32'h0);
      chk("hresp", 32'(hresp), 32'h0);
      ahb(1'b1, 32'(OFS_CTRL), 32'h1);
      serial_host_model_inst.send(mk_ref(SEL_IF_REF, 14'h3FFF, 0, 1, 0), 1);
      chk("if_ref_div", 32'(if_ref_div), 32'h3FFF);
      chk("if_cp_tristate", 32'(if_cp_tristate), 32'h1);
      chk("if_cp_current", 32'(if_cp_current), 32'h0);
      print_verdict();
   end
endmodule // dual_pll_serial_control_latches_tb_top

// >>> bench/serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model #(
   parameter int HALF = 4
) (
   // Clock
   input  wire logic hclk,
   // Three-wire serial port
   output logic      shift_clock,
   output logic      serial_in,
   output logic      load_strobe
);
   initial begin
      shift_clock = 1'b0;
      serial_in   = 1'b0;
      load_strobe = 1'b0;
   end

   // Four hclk cycles per level give 15.6 MHz, below the 20 MHz ceiling.
   task automatic send(input logic [synth_pkg::WORD_W-1:0] w,
                       input logic do_load);
      load_strobe <= 1'b0;
      repeat (HALF) @(posedge hclk);
      for (int i = synth_pkg::WORD_W - 1; i >= 0; i--) begin
         serial_in   <= w[i];
         shift_clock <= 1'b0;
         repeat (HALF) @(posedge hclk);
         shift_clock <= 1'b1;
         repeat (HALF) @(posedge hclk);
      end
      // The data line is not held after the frame, so it flips.
      shift_clock <= 1'b0;
      serial_in   <= ~w[0];
      repeat (HALF) @(posedge hclk);
      load_strobe <= do_load;
      repeat (5) @(posedge hclk);
   endtask
endmodule // serial_host_model

// >>> include/synth_pkg.sv
package synth_pkg;
   // Serial word layout.
   localparam int          WORD_W      = 22;
   localparam int          SEL_LO_BIT  = 0;
   localparam int          SEL_HI_BIT  = 1;
   localparam logic [1:0]  SEL_IF_REF  = 2'h0;
   localparam logic [1:0]  SEL_IF_AB   = 2'h1;
   localparam logic [1:0]  SEL_RF_REF  = 2'h2;
   localparam logic [1:0]  SEL_RF_AB   = 2'h3;
   localparam int          NUM_LATCH   = 4;
   // Reference latch fields.
   localparam int          REF_LSB     = 2;
   localparam int          REF_W       = 14;
   localparam int          POL_BIT     = 16;
   localparam int          TRI_BIT     = 17;
   localparam int          CUR_BIT     = 18;
   // AB latch fields.
   localparam int          A_LSB       = 2;
   localparam int          A_W         = 6;
   localparam int          FAST_BIT    = 8;
   localparam int          B_LSB       = 9;
   localparam int          B_W         = 11;
   localparam int          PRESC_BIT   = 20;
   // Register map, byte addresses.
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_STATUS  = 8'h04;
   localparam logic [7:0]  OFS_LATCH0  = 8'h08;
   localparam int          CTRL_EN_BIT = 0;
   localparam logic        CTRL_RESET  = 1'b1;
   localparam int          ST_ACT_BIT  = 4;
   localparam int          ST_FAST_BIT = 5;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
endpackage

// >>> rtl/dual_pll_serial_control_latches.sv
`timescale 1ns/1ns
// Functional notes
// [RULE1] Each rising shift_clock shifts serial_in into a 22-bit word.
// [RULE2] Rising load_strobe copies the word into the selected latch. The code ignores it while the CTRL enable bit is clear.
// [RULE3] Select 0,0 loads the IF reference latch with a 14-bit divide.
// [RULE4] Select 0,1 loads the IF AB latch: 6-bit A, 11-bit B.
// [RULE5] Select 1,0 loads the RF reference latch with a 14-bit divide.
// [RULE6] Select 1,1 loads the RF AB latch: 6-bit A, 11-bit B.
// [RULE7] if_pfd_polarity sets IF detector sense; host picks by VCO slope.
// [RULE8] if_cp_tristate one puts the IF charge pump in high impedance.
// [RULE9] if_cp_current selects IF pump current low or high.
// [RULE10] if_prescaler_sel selects IF prescaler 8/9 or 16/17.
// [RULE11] rf_pfd_polarity sets RF detector sense; host picks by VCO slope.
// [RULE12] rf_cp_tristate one puts the RF charge pump in high impedance.
// [RULE13] rf_cp_current selects RF pump current low or high.
// [RULE14] rf_prescaler_sel selects RF prescaler 32/33 or 64/65.
// [RULE15] fastlock_enable forces RF pump current high and drives damping.
// [RULE16] Host leaves fastlock by rewriting RF AB latch, fastlock cleared.
// [RULE17] Host keeps shift_clock at or below 20 MHz.
// [RULE18] Host holds load_strobe low, shifts 22 bits, then raises it.
// [RULE19] Outputs stay inactive until all four latches have been written; prescaler, polarity and current flags follow their latches before that.
// [RULE20] Latches hold their value until rewritten with the same select.
module dual_pll_serial_control_latches (
   // Clock, reset, clock enable
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     ce,
   // Three-wire serial port
   input  wire logic                     shift_clock,
   input  wire logic                     serial_in,
   input  wire logic                     load_strobe,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic [31:0]                   hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   // IF synthesizer controls
   output logic [synth_pkg::REF_W-1:0]   if_ref_div,
   output logic [synth_pkg::A_W-1:0]     if_a_count,
   output logic [synth_pkg::B_W-1:0]     if_b_count,
   output logic                          if_prescaler_sel,
   output logic                          if_pfd_polarity,
   output logic                          if_cp_tristate,
   output logic                          if_cp_current,
   // RF synthesizer controls
   output logic [synth_pkg::REF_W-1:0]   rf_ref_div,
   output logic [synth_pkg::A_W-1:0]     rf_a_count,
   output logic [synth_pkg::B_W-1:0]     rf_b_count,
   output logic                          rf_prescaler_sel,
   output logic                          rf_pfd_polarity,
   output logic                          rf_cp_tristate,
   output logic                          rf_cp_current,
   output logic                          damping_switch_out,
   output logic                          synth_active
);
   import synth_pkg::*;

   logic [WORD_W-1:0]    word_q;
   logic                 load_pulse_q;
   logic [WORD_W-1:0]    latch_q [NUM_LATCH];
   logic [NUM_LATCH-1:0] loaded_q;
   logic                 ctrl_en_q;
   logic                 ctrl_en_d;

   serial_word_capture u_capture (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .ce           (ce),
      .shift_clock  (shift_clock),
      .serial_in    (serial_in),
      .load_strobe  (load_strobe),
      .port_enable  (ctrl_en_q),
      .word_q       (word_q),
      .load_pulse_q (load_pulse_q)
   );

   // One latch per select code; only a matching load touches it.
   for (genvar i = 0; i < NUM_LATCH; i++) begin : g_latch
      logic [WORD_W-1:0] lat_d;
      logic              ld_d;
      logic              hit;
      always_comb begin
         hit   = load_pulse_q
               && ({word_q[SEL_HI_BIT], word_q[SEL_LO_BIT]} == 2'(i)); // RULE2
         lat_d = hit ? word_q : latch_q[i]; // RULE20
         ld_d  = loaded_q[i] | hit; // RULE19
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            latch_q[i]  <= '0;
            loaded_q[i] <= 1'b0;
         end else if (ce) begin
            latch_q[i]  <= lat_d;
            loaded_q[i] <= ld_d;
         end
      end
   end

   // Output decode. Dividers read zero and both pumps float until the
   // four latches are written, so a half-programmed loop never drives.
   logic [WORD_W-1:0]  ifr;
   logic [WORD_W-1:0]  ifab;
   logic [WORD_W-1:0]  rfr;
   logic [WORD_W-1:0]  rfab;
   logic               act_d;
   logic               fast;
   logic [REF_W-1:0]   if_ref_d;
   logic [A_W-1:0]     if_a_d;
   logic [B_W-1:0]     if_b_d;
   logic [REF_W-1:0]   rf_ref_d;
   logic [A_W-1:0]     rf_a_d;
   logic [B_W-1:0]     rf_b_d;
   logic [7:0]         flags_d;

   always_comb begin
      ifr      = latch_q[SEL_IF_REF];
      ifab     = latch_q[SEL_IF_AB];
      rfr      = latch_q[SEL_RF_REF];
      rfab     = latch_q[SEL_RF_AB];
      act_d    = &loaded_q; // RULE19
      fast     = act_d && rfab[FAST_BIT]; // RULE15
      if_ref_d = act_d ? ifr[REF_LSB +: REF_W] : '0; // RULE3
      if_a_d   = act_d ? ifab[A_LSB +: A_W] : '0; // RULE4
      if_b_d   = act_d ? ifab[B_LSB +: B_W] : '0; // RULE4
      rf_ref_d = act_d ? rfr[REF_LSB +: REF_W] : '0; // RULE5
      rf_a_d   = act_d ? rfab[A_LSB +: A_W] : '0; // RULE6
      rf_b_d   = act_d ? rfab[B_LSB +: B_W] : '0; // RULE6
      flags_d[0] = ifab[PRESC_BIT]; // RULE10
      flags_d[1] = ifr[POL_BIT]; // RULE7
      flags_d[2] = !act_d || ifr[TRI_BIT]; // RULE8
      flags_d[3] = ifr[CUR_BIT]; // RULE9
      flags_d[4] = rfab[PRESC_BIT]; // RULE14
      flags_d[5] = rfr[POL_BIT]; // RULE11
      flags_d[6] = !act_d || rfr[TRI_BIT]; // RULE12
      flags_d[7] = rfr[CUR_BIT] || fast; // RULE13 RULE15
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         if_ref_div         <= '0;
         if_a_count         <= '0;
         if_b_count         <= '0;
         rf_ref_div         <= '0;
         rf_a_count         <= '0;
         rf_b_count         <= '0;
         if_prescaler_sel   <= 1'b0;
         if_pfd_polarity    <= 1'b0;
         if_cp_tristate     <= 1'b1;
         if_cp_current      <= 1'b0;
         rf_prescaler_sel   <= 1'b0;
         rf_pfd_polarity    <= 1'b0;
         rf_cp_tristate     <= 1'b1;
         rf_cp_current      <= 1'b0;
         damping_switch_out <= 1'b0;
         synth_active       <= 1'b0;
      end else if (ce) begin
         if_ref_div         <= if_ref_d;
         if_a_count         <= if_a_d;
         if_b_count         <= if_b_d;
         rf_ref_div         <= rf_ref_d;
         rf_a_count         <= rf_a_d;
         rf_b_count         <= rf_b_d;
         if_prescaler_sel   <= flags_d[0];
         if_pfd_polarity    <= flags_d[1];
         if_cp_tristate     <= flags_d[2];
         if_cp_current      <= flags_d[3];
         rf_prescaler_sel   <= flags_d[4];
         rf_pfd_polarity    <= flags_d[5];
         rf_cp_tristate     <= flags_d[6];
         rf_cp_current      <= flags_d[7];
         damping_switch_out <= fast; // RULE15
         synth_active       <= act_d;
      end
   end

   // AHB-Lite slave, zero wait states. Read data is fetched during the
   // address phase so hrdata comes from a flop in the data phase.
   logic        wr_pend_q;
   logic        wr_pend_d;
   logic [7:0]  wr_addr_q;
   logic [7:0]  wr_addr_d;
   logic [31:0] hrdata_d;
   logic        take;
   logic [7:0]  ofs;

   always_comb begin
      take      = hsel && hready && (htrans == HTRANS_NSEQ);
      ofs       = haddr[7:0];
      // Writes outside the map are dropped here so they cannot alias onto
      // the control word through the low address byte.
      wr_pend_d = take && hwrite && (haddr[31:8] == 24'h00_0000);
      wr_addr_d = take ? ofs : wr_addr_q;
      hrdata_d  = 32'h0000_0000;
      ctrl_en_d = ctrl_en_q;
      if (wr_pend_q && (wr_addr_q == OFS_CTRL)) begin
         ctrl_en_d = hwdata[CTRL_EN_BIT];
      end
      if (take && !hwrite) begin
         if (haddr[31:8] != 24'h00_0000) begin
            hrdata_d = 32'h0000_0000;
         end else if (ofs == OFS_CTRL) begin
            hrdata_d[CTRL_EN_BIT] = ctrl_en_q;
         end else if (ofs == OFS_STATUS) begin
            hrdata_d[NUM_LATCH-1:0] = loaded_q;
            hrdata_d[ST_ACT_BIT]    = synth_active;
            hrdata_d[ST_FAST_BIT]   = damping_switch_out;
         end else if (ofs == OFS_LATCH0) begin
            hrdata_d[WORD_W-1:0] = latch_q[SEL_IF_REF];
         end else if (ofs == OFS_LATCH0 + 8'h04) begin
            hrdata_d[WORD_W-1:0] = latch_q[SEL_IF_AB];
         end else if (ofs == OFS_LATCH0 + 8'h08) begin
            hrdata_d[WORD_W-1:0] = latch_q[SEL_RF_REF];
         end else if (ofs == OFS_LATCH0 + 8'h0C) begin
            hrdata_d[WORD_W-1:0] = latch_q[SEL_RF_AB];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         ctrl_en_q <= CTRL_RESET;
      end else if (ce) begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         hrdata    <= hrdata_d;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         ctrl_en_q <= ctrl_en_d;
      end
   end

   // Checks.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_load(logic [1:0] code);
      ce && load_pulse_q
      && ({word_q[SEL_HI_BIT], word_q[SEL_LO_BIT]} == code) ##1 ce;
   endsequence

   a_if_ref_load: assert property ( // RULE3
      s_load(SEL_IF_REF) |-> latch_q[SEL_IF_REF] == $past(word_q))
      else $error("IF reference latch not loaded");
   a_if_ab_load: assert property ( // RULE4
      s_load(SEL_IF_AB) |-> latch_q[SEL_IF_AB] == $past(word_q))
      else $error("IF AB latch not loaded");
   a_rf_ref_load: assert property ( // RULE5
      s_load(SEL_RF_REF) ##1 ce |-> rf_ref_div == (synth_active
         ? $past(word_q[REF_LSB +: REF_W], 2) : '0))
      else $error("RF reference divider output wrong");
   a_rf_ab_load: assert property ( // RULE6
      s_load(SEL_RF_AB) |-> latch_q[SEL_RF_AB] == $past(word_q)
         && latch_q[SEL_IF_REF] == $past(latch_q[SEL_IF_REF]))
      else $error("RF AB latch load wrong or disturbed others");
   a_latch_hold: assert property ( // RULE20
      !load_pulse_q |=> $stable(latch_q[SEL_IF_AB])
         && $stable(latch_q[SEL_RF_AB]))
      else $error("latch changed without a load");
   a_inactive_float: assert property ( // RULE19
      ce && !(&loaded_q) |=> if_cp_tristate && rf_cp_tristate
         && !synth_active && if_b_count == '0)
      else $error("outputs active before four writes");
   a_if_tristate: assert property ( // RULE8
      ce && &loaded_q
      |=> if_cp_tristate == $past(latch_q[SEL_IF_REF][TRI_BIT]))
      else $error("IF charge pump three-state wrong");
   a_fastlock_pump: assert property ( // RULE15
      ce && &loaded_q && latch_q[SEL_RF_AB][FAST_BIT]
      |=> rf_cp_current && damping_switch_out)
      else $error("fastlock did not force pump and damping");
   a_fastlock_off: assert property ( // RULE15
      ce && !latch_q[SEL_RF_AB][FAST_BIT] |=> !damping_switch_out)
      else $error("damping switch on without fastlock");

   // Each flag output must track its own latch bit one edge later, the pump
   // three-states once all four latches are loaded and rf_cp_current while
   // fastlock is clear. These are written against the latch array, not the
   // decode, so a swapped bit position in the output mux is caught.
   a_if_polarity: assert property ( // RULE7
      ce |=> if_pfd_polarity == $past(latch_q[SEL_IF_REF][POL_BIT]))
      else $error("IF detector polarity does not follow its latch");
   a_if_current: assert property ( // RULE9
      ce |=> if_cp_current == $past(latch_q[SEL_IF_REF][CUR_BIT]))
      else $error("IF pump current does not follow its latch");
   a_if_prescaler: assert property ( // RULE10
      ce |=> if_prescaler_sel == $past(latch_q[SEL_IF_AB][PRESC_BIT]))
      else $error("IF prescaler select does not follow its latch");
   a_rf_polarity: assert property ( // RULE11
      ce |=> rf_pfd_polarity == $past(latch_q[SEL_RF_REF][POL_BIT]))
      else $error("RF detector polarity does not follow its latch");
   a_rf_tristate: assert property ( // RULE12
      ce && &loaded_q
      |=> rf_cp_tristate == $past(latch_q[SEL_RF_REF][TRI_BIT]))
      else $error("RF charge pump three-state wrong");
   a_rf_current: assert property ( // RULE13
      ce && !latch_q[SEL_RF_AB][FAST_BIT]
      |=> rf_cp_current == $past(latch_q[SEL_RF_REF][CUR_BIT]))
      else $error("RF pump current does not follow its latch");
   a_rf_prescaler: assert property ( // RULE14
      ce |=> rf_prescaler_sel == $past(latch_q[SEL_RF_AB][PRESC_BIT]))
      else $error("RF prescaler select does not follow its latch");
endmodule // dual_pll_serial_control_latches

// >>> rtl/serial_word_capture.sv
`timescale 1ns/1ns
module serial_word_capture (
   // Clock and reset
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       ce,
   // Serial pins, synchronous to hclk, and the port enable
   input  wire logic                       shift_clock,
   input  wire logic                       serial_in,
   input  wire logic                       load_strobe,
   input  wire logic                       port_enable,
   // Captured word
   output logic [synth_pkg::WORD_W-1:0]    word_q,
   output logic                            load_pulse_q
);
   import synth_pkg::*;

   logic              sclk_prev_q;
   logic              sclk_prev_d;
   logic              le_prev_q;
   logic              le_prev_d;
   logic [WORD_W-1:0] word_d;
   logic              load_pulse_d;

   always_comb begin
      sclk_prev_d  = shift_clock;
      le_prev_d    = load_strobe;
      word_d       = word_q;
      if (shift_clock && !sclk_prev_q) begin
         word_d = {word_q[WORD_W-2:0], serial_in}; // RULE1
      end
      load_pulse_d = load_strobe && !le_prev_q && port_enable; // RULE2
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_prev_q  <= 1'b0;
         le_prev_q    <= 1'b0;
         word_q       <= '0;
         load_pulse_q <= 1'b0;
      end else if (ce) begin
         sclk_prev_q  <= sclk_prev_d;
         le_prev_q    <= le_prev_d;
         word_q       <= word_d;
         load_pulse_q <= load_pulse_d;
      end
   end

   a_shift_in_bit: assert property ( // RULE1
      @(posedge hclk) disable iff (!hresetn)
      (ce && shift_clock && !sclk_prev_q)
      |=> word_q == {$past(word_q[WORD_W-2:0]), $past(serial_in)})
      else $error("shift register did not take serial_in");
endmodule // serial_word_capture
